// file: hw/egu_gearing.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Each of eight slaves follows its chosen master both ways, with its own ratio writable at any time.
// - A ratio is a signed value up to 127.9999 in steps of .0001, held as ten-thousandths.
// - Writing a zero ratio turns gearing off for that axis in either mode.
// - A limit or stop on a slave in standard mode ends its gearing, but not in gantry mode.
// - A per-axis gantry bit of one selects gantry mode and zero selects standard mode.
// - By default the slave follows the master axis encoder position.
// - The source may instead be the commanded position of the master axis.
// - The source may instead be the distance moved along the coordinated vector path.
// - An axis's own commanded move adds on top of its geared motion.
// - The free segment count reads zero when full and 512 when empty.
// - The segment counter gives the executing segment index, starting at zero.
// - The distance travelled along the sequence path is readable.
// - Each axis keeps the absolute coordinate of the last passed segment boundary.
// - The total vector length of the sequence is readable.
module egu_gearing
  import egu_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       sample_i,
  input  wire egu_vec_t   enc_pos_i,
  input  wire egu_vec_t   cmd_pos_i,
  input  wire egu_vec_t   move_delta_i,
  input  wire logic [7:0] stop_i,
  input  wire logic [7:0] limit_i,
  input  wire egu_seq_s   seq_i,
  input  wire egu_bus_s   bus_i,
  output logic [31:0]     rdata_o,
  output egu_vec_t        slave_cmd_o,
  output logic [7:0]      gear_on_o
);

  egu_state_s s;
  egu_state_s next_s;

  logic signed [31:0] mdelta [8];
  logic signed [55:0] total  [8];
  logic signed [55:0] quot   [8];
  logic signed [55:0] remd   [8];
  logic signed [21:0] wr_ratio;

  function automatic logic egu_hit(input logic [7:0] addr, input logic [7:0] base);
    egu_hit = (addr[7:5] == base[7:5]);
  endfunction

  function automatic logic signed [31:0] egu_pick(
    input logic [4:0] sel,
    input egu_vec_t   enc,
    input egu_vec_t   encp,
    input egu_vec_t   cmd,
    input egu_vec_t   cmdp,
    input logic [31:0] vec
  );
    logic [2:0] ax;
    ax = sel[SRC_TYPE_LSB-1:SRC_AXIS_LSB];
    unique case (egu_src_e'(sel[SRC_TYPE_LSB+:2]))
      EGU_SRC_ENC: egu_pick = enc[ax] - encp[ax];
      EGU_SRC_CMD: egu_pick = cmd[ax] - cmdp[ax];
      EGU_SRC_VEC: egu_pick = vec;
      default:     egu_pick = 32'h0;
    endcase
  endfunction

  // Ratios beyond the range saturate rather than wrap.
  always_comb begin
    if ($signed(bus_i.wdata) > $signed(32'(RATIO_MAX))) begin
      wr_ratio = RATIO_MAX;
    end else if ($signed(bus_i.wdata) < -$signed(32'(RATIO_MAX))) begin
      wr_ratio = -RATIO_MAX;
    end else begin
      wr_ratio = bus_i.wdata[21:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-axis gear arithmetic. The remainder keeps sign of the total, so the
  // sub-count part is carried forward exactly and never dropped.
  for (genvar a = 0; a < 8; a++) begin : g_axis
    always_comb begin
      mdelta[a] = egu_pick(s.src[a], enc_pos_i, s.enc_prev, cmd_pos_i, s.cmd_prev,
                           seq_i.path_delta);
      total[a]  = 56'(mdelta[a]) * 56'($signed(s.ratio[a]))
                + 56'($signed(s.rem[a]));
      quot[a]   = total[a] / $signed(56'(RATIO_SCALE));
      remd[a]   = total[a] % $signed(56'(RATIO_SCALE));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s       = s;
    next_s.rdata = 32'h0;
    if (ce_i) begin
      next_s.lim_s1 = limit_i;
      next_s.lim_s2 = s.lim_s1;
      if (sample_i) begin
        next_s.enc_prev = enc_pos_i;
        next_s.cmd_prev = cmd_pos_i;
        for (int a = 0; a < 8; a++) begin
          if (s.gear_on[a]) begin
            next_s.slave_pos[a] = s.slave_pos[a] + quot[a][31:0]
                                + move_delta_i[a];
            next_s.rem[a] = remd[a][14:0];
          end else begin
            next_s.slave_pos[a] = s.slave_pos[a] + move_delta_i[a];
          end
        end
      end
      for (int a = 0; a < 8; a++) begin
        if (!s.gantry[a] && (s.lim_s2[a] || stop_i[a])) begin
          next_s.gear_on[a] = 1'b0;
          next_s.rem[a]     = 15'h0;
        end
      end
      if (bus_i.wr) begin
        if (egu_hit(bus_i.addr, RATIO_BASE)) begin
          // A new ratio takes effect on the next sample, even mid-motion.
          next_s.ratio[bus_i.addr[4:2]]   = wr_ratio;
          next_s.gear_on[bus_i.addr[4:2]] = (wr_ratio != 22'sh0);
          if (wr_ratio == 22'sh0) begin
            next_s.rem[bus_i.addr[4:2]] = 15'h0;
          end
        end else if (bus_i.addr == GANTRY_ADDR) begin
          next_s.gantry = bus_i.wdata[7:0];
        end else if (egu_hit(bus_i.addr, SRC_BASE)) begin
          next_s.src[bus_i.addr[4:2]] = bus_i.wdata[4:0];
        end
      end
      if (seq_i.clear) begin
        next_s.free_cnt  = SEQ_DEPTH;
        next_s.seg_cnt   = 10'h0;
        next_s.path_dist = 32'h0;
        next_s.total_len = 32'h0;
      end else begin
        if (seq_i.load && s.free_cnt != 10'h0 && !(seq_i.advance && s.free_cnt != SEQ_DEPTH)) begin
          next_s.free_cnt = s.free_cnt - 10'h1;
        end else if (seq_i.advance && s.free_cnt != SEQ_DEPTH && !(seq_i.load && s.free_cnt != 10'h0)) begin
          next_s.free_cnt = s.free_cnt + 10'h1;
        end
        if (seq_i.load) begin
          next_s.total_len = s.total_len + seq_i.seg_len;
        end
        if (seq_i.advance) begin
          next_s.seg_cnt = s.seg_cnt + 10'h1;
          next_s.bound   = cmd_pos_i;
        end
        if (sample_i) begin
          next_s.path_dist = s.path_dist + seq_i.path_delta;
        end
      end
      if (bus_i.rd) begin
        if (egu_hit(bus_i.addr, RATIO_BASE)) begin
          next_s.rdata = 32'($signed(s.ratio[bus_i.addr[4:2]]));
        end else if (bus_i.addr == GANTRY_ADDR) begin
          next_s.rdata = {24'h0, s.gantry};
        end else if (egu_hit(bus_i.addr, SRC_BASE)) begin
          next_s.rdata = {27'h0, s.src[bus_i.addr[4:2]]};
        end else if (bus_i.addr == FREE_ADDR) begin
          next_s.rdata = {22'h0, s.free_cnt};
        end else if (bus_i.addr == SEGCNT_ADDR) begin
          next_s.rdata = {22'h0, s.seg_cnt};
        end else if (bus_i.addr == PATH_ADDR) begin
          next_s.rdata = s.path_dist;
        end else if (bus_i.addr == TOTAL_ADDR) begin
          next_s.rdata = s.total_len;
        end else if (egu_hit(bus_i.addr, BOUND_BASE)) begin
          next_s.rdata = s.bound[bus_i.addr[4:2]];
        end else if (egu_hit(bus_i.addr, SLAVE_BASE)) begin
          next_s.rdata = s.slave_pos[bus_i.addr[4:2]];
        end
      end
    end else begin
      next_s.rdata = s.rdata;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s          <= '0;
      s.src      <= {8{SRC_RESET}};
      s.free_cnt <= SEQ_DEPTH;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_o     = s.rdata;
  assign slave_cmd_o = s.slave_pos;
  assign gear_on_o   = s.gear_on;

  ////////////////////////////////////////////////////////////////////////////
  free_bound_a:
    assert property (@(posedge mclk_i) disable iff (rst_i) s.free_cnt <= SEQ_DEPTH)
    else $error("free count above depth");

  ratio_range_a:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      $signed(s.ratio[0]) <= RATIO_MAX && $signed(s.ratio[0]) >= -RATIO_MAX)
    else $error("ratio out of range");

  zero_ratio_a:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_i && bus_i.wr && bus_i.addr == RATIO_BASE && bus_i.wdata == 32'h0
      |=> !s.gear_on[0])
    else $error("zero ratio left gearing on");

  stop_std_a:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_i && stop_i[1] && !s.gantry[1] && !bus_i.wr
      |=> !s.gear_on[1])
    else $error("stop did not end standard gearing");

  stop_gantry_a:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_i && stop_i[2] && s.gantry[2] && s.gear_on[2] && !bus_i.wr
      |=> s.gear_on[2])
    else $error("stop ended gantry gearing");

  seg_clear_a:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_i && seq_i.clear |=> s.seg_cnt == 10'h0 && s.free_cnt == SEQ_DEPTH)
    else $error("clear did not reset sequence");

  seg_step_a:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_i && seq_i.advance && !seq_i.clear |=> s.seg_cnt == $past(s.seg_cnt) + 10'h1)
    else $error("segment counter did not step");

  total_len_a:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_i && seq_i.load && !seq_i.clear
      |=> s.total_len == $past(s.total_len) + $past(seq_i.seg_len))
    else $error("total length not accumulated");

  move_add_a:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_i && sample_i && !s.gear_on[0]
      |=> s.slave_pos[0] == $past(s.slave_pos[0]) + $past(move_delta_i[0]))
    else $error("own move not added");

  read_free_a:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_i && bus_i.rd && bus_i.addr == FREE_ADDR
      |=> rdata_o == {22'h0, $past(s.free_cnt)})
    else $error("free count read wrong");

  ratio_write_a:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_i && bus_i.wr && bus_i.addr == RATIO_BASE && $signed(bus_i.wdata) == RATIO_SCALE
      |=> $signed(s.ratio[0]) == RATIO_SCALE && s.gear_on[0])
    else $error("ratio write not taken");

  ratio_sat_a:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_i && bus_i.wr && egu_hit(bus_i.addr, RATIO_BASE) && bus_i.addr[4:2] == 3'h3
      && $signed(bus_i.wdata) > $signed(32'(RATIO_MAX))
      |=> s.ratio[3] == RATIO_MAX)
    else $error("ratio did not saturate");

  rem_zero_a:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_i && bus_i.wr && bus_i.addr == RATIO_BASE && bus_i.wdata == 32'h0
      |=> s.rem[0] == 15'h0 && s.ratio[0] == 22'h0)
    else $error("zero ratio left a remainder");

  gantry_write_a:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_i && bus_i.wr && bus_i.addr == GANTRY_ADDR
      |=> s.gantry == $past(bus_i.wdata[7:0]))
    else $error("gantry select not taken");

  limit_std_a:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_i && s.lim_s2[1] && !s.gantry[1] && !bus_i.wr |=> !s.gear_on[1])
    else $error("limit did not end standard gearing");

  limit_gantry_a:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_i && s.lim_s2[2] && s.gantry[2] && s.gear_on[2] && !bus_i.wr |=> s.gear_on[2])
    else $error("limit ended gantry gearing");

  // Whole counts times the scale plus the remainder must match master change times
  // ratio plus the old remainder, so any dropped fraction shows up here.
  enc_follow_a:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_i && sample_i && s.gear_on[1] && s.src[1] == 5'h00 && !stop_i[1] && !s.lim_s2[1]
      && !bus_i.wr
      |=> 56'($signed(s.slave_pos[1] - $past(s.slave_pos[1]) - $past(move_delta_i[1])))
            * 56'(RATIO_SCALE) + 56'($signed(s.rem[1]))
          == 56'($signed($past(enc_pos_i[0]) - $past(s.enc_prev[0])))
            * 56'($signed($past(s.ratio[1]))) + 56'($signed($past(s.rem[1]))))
    else $error("encoder gearing lost counts");

  cmd_follow_a:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_i && sample_i && s.gear_on[2] && s.src[2] == 5'h08 && s.rem[2] == 15'h0
      && $signed(s.ratio[2]) == RATIO_SCALE
      |=> s.slave_pos[2] == $past(s.slave_pos[2]) + $past(cmd_pos_i[0])
          - $past(s.cmd_prev[0]) + $past(move_delta_i[2]))
    else $error("commanded master not followed");

  vec_follow_a:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_i && sample_i && s.gear_on[3] && egu_src_e'(s.src[3][SRC_TYPE_LSB+:2]) == EGU_SRC_VEC
      && !stop_i[3] && !s.lim_s2[3] && !bus_i.wr
      |=> 56'($signed(s.slave_pos[3] - $past(s.slave_pos[3]) - $past(move_delta_i[3])))
            * 56'(RATIO_SCALE) + 56'($signed(s.rem[3]))
          == 56'($signed($past(seq_i.path_delta))) * 56'($signed($past(s.ratio[3])))
            + 56'($signed($past(s.rem[3]))))
    else $error("vector gearing lost counts");

  path_step_a:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_i && sample_i && !seq_i.clear |=> s.path_dist == $past(s.path_dist) + $past(seq_i.path_delta))
    else $error("path distance not accumulated");

  bound_latch_a:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_i && seq_i.advance && !seq_i.clear |=> s.bound == $past(cmd_pos_i))
    else $error("boundary coordinates not taken");

  free_load_a:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_i && seq_i.load && !seq_i.advance && !seq_i.clear && s.free_cnt != 10'h0
      |=> s.free_cnt == $past(s.free_cnt) - 10'h1)
    else $error("load did not take a free entry");

  free_adv_a:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_i && seq_i.advance && !seq_i.load && !seq_i.clear && s.free_cnt != SEQ_DEPTH
      |=> s.free_cnt == $past(s.free_cnt) + 10'h1)
    else $error("advance did not free an entry");

  free_full_a:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_i && seq_i.load && !seq_i.advance && !seq_i.clear && s.free_cnt == 10'h0
      |=> s.free_cnt == 10'h0)
    else $error("full buffer count wrapped");

  // The enable gates every register, so a low enable must leave the whole state untouched.
  ce_hold_a:
    assert property (@(posedge mclk_i) disable iff (rst_i) !ce_i |=> $stable(s))
    else $error("state moved with enable low");

  read_idle_a:
    assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_i && !bus_i.rd |=> rdata_o == 32'h0)
    else $error("read data did not return to zero");

endmodule // egu_gearing

`default_nettype wire

// file: hw/egu_pkg.sv
package egu_pkg;

  // Register byte addresses (word aligned, eight-bit address port).
  localparam logic [7:0] RATIO_BASE  = 8'h00;
  localparam logic [7:0] GANTRY_ADDR = 8'h20;
  localparam logic [7:0] SRC_BASE    = 8'h40;
  localparam logic [7:0] FREE_ADDR   = 8'h80;
  localparam logic [7:0] SEGCNT_ADDR = 8'h84;
  localparam logic [7:0] PATH_ADDR   = 8'h88;
  localparam logic [7:0] TOTAL_ADDR  = 8'h8c;
  localparam logic [7:0] BOUND_BASE  = 8'ha0;
  localparam logic [7:0] SLAVE_BASE  = 8'hc0;

  // Ratio is a signed count of ten-thousandths.
  localparam int                RATIO_SCALE = 10000;
  localparam logic signed [21:0] RATIO_MAX  = 22'sh1387ff;
  localparam logic [9:0]         SEQ_DEPTH  = 10'h200;

  // Source select field layout.
  localparam int SRC_AXIS_LSB = 0;
  localparam int SRC_TYPE_LSB = 3;
  localparam logic [4:0] SRC_RESET = 5'h00;

  typedef enum logic [1:0] {
    EGU_SRC_ENC,
    EGU_SRC_CMD,
    EGU_SRC_VEC
  } egu_src_e;

  typedef logic [7:0][31:0] egu_vec_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } egu_bus_s;

  typedef struct packed {
    logic        load;
    logic        advance;
    logic        clear;
    logic [31:0] seg_len;
    logic [31:0] path_delta;
  } egu_seq_s;

  typedef struct packed {
    logic [7:0][21:0] ratio;
    logic [7:0][4:0]  src;
    logic [7:0]       gantry;
    logic [7:0]       gear_on;
    logic [7:0]       lim_s1;
    logic [7:0]       lim_s2;
    egu_vec_t         enc_prev;
    egu_vec_t         cmd_prev;
    egu_vec_t         slave_pos;
    logic [7:0][14:0] rem;
    egu_vec_t         bound;
    logic [9:0]       free_cnt;
    logic [9:0]       seg_cnt;
    logic [31:0]      path_dist;
    logic [31:0]      total_len;
    logic [31:0]      rdata;
  } egu_state_s;

endpackage

// file: tb/egu_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// Master axis stand-in: each step request moves axis 0 and raises one servo sample.
module egu_master_model
  import egu_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        step_i,
  input  wire logic [31:0] enc_step_i,
  input  wire logic [31:0] cmd_step_i,
  output logic             sample_o,
  output egu_vec_t         enc_pos_o,
  output egu_vec_t         cmd_pos_o
);
  // Positions and sample change on the same edge, so the block never sees a stale master.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sample_o  <= 1'b0;
      enc_pos_o <= '0;
      cmd_pos_o <= '0;
    end else begin
      sample_o <= step_i;
      if (step_i) begin
        enc_pos_o[0] <= enc_pos_o[0] + enc_step_i;
        cmd_pos_o[0] <= cmd_pos_o[0] + cmd_step_i;
      end
    end
  end
endmodule // egu_master_model
`default_nettype wire

// file: tb/test_electronic_gearing_unit.sv
`timescale 1ns/1ps
`default_nettype none
module test_electronic_gearing_unit
  import egu_pkg::*;
;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} egu_row_s;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        step = 1'b0;
  logic [31:0] es = '0;
  logic [31:0] cs = 32'h7;
  logic [7:0]  stop = '0;
  logic [7:0]  limit = '0;
  egu_vec_t    move = '0;
  egu_seq_s    seq = '0;
  egu_bus_s    bus = '0;
  egu_vec_t    enc, cmd, slave;
  logic        sample;
  logic [31:0] rdata;
  logic [7:0]  gon;
  int          fail_count = 0;
  int          checked = 0;
  // Saturation, read-only and unmapped places sit beside plain ratio writes.
  egu_row_s rows [9] = '{'{8'h00, 32'h2710, 32'h2710}, '{8'h04, 32'hffec7801, 32'hffec7801},
    '{8'h08, 32'h1, 32'h1}, '{8'h0c, 32'h13d620, 32'h1387ff}, '{8'h20, 32'ha5, 32'ha5},
    '{8'h44, 32'h9, 32'h9}, '{8'h80, 32'h5, 32'h200}, '{8'he0, 32'h55, 32'h0},
    '{8'h00, 32'h0, 32'h0}};

  egu_master_model mdl (.mclk_i(mclk), .rst_i(rst), .step_i(step), .enc_step_i(es),
    .cmd_step_i(cs), .sample_o(sample), .enc_pos_o(enc), .cmd_pos_o(cmd));
  egu_gearing uut (.mclk_i(mclk), .rst_i(rst), .ce_i(ce), .sample_i(sample), .enc_pos_i(enc),
    .cmd_pos_i(cmd), .move_delta_i(move), .stop_i(stop), .limit_i(limit), .seq_i(seq),
    .bus_i(bus), .rdata_o(rdata), .slave_cmd_o(slave), .gear_on_o(gon));

  always #5 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk); bus.addr <= a; bus.wdata <= v; bus.wr <= 1'b1;
    @(posedge mclk); bus.wr <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk); bus.addr <= a; bus.rd <= 1'b1;
    @(posedge mclk); bus.rd <= 1'b0;
    #1 chk(n, rdata, e);
  endtask
  task automatic do_reset;
    rst <= 1'b1;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
  endtask
  task automatic stepm(input logic [31:0] e);
    @(posedge mclk); es <= e; step <= 1'b1;
    @(posedge mclk); step <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic pulse_seq(input int n, input bit ld, input bit adv, input bit clr);
    @(posedge mclk); seq.load <= ld; seq.advance <= adv; seq.clear <= clr;
    repeat (n) @(posedge mclk);
    seq.load <= 1'b0; seq.advance <= 1'b0; seq.clear <= 1'b0;
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seq.path_delta <= 32'h5;
    seq.seg_len <= 32'h64;
    do_reset;
    rchk("free_count", 8'h80, 32'h200);
    rchk("seg_count", 8'h84, 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rchk("reg_row", rows[i].a, rows[i].e);
    end
    $display("register table done");
    @(posedge mclk);
    do_reset;
    chk("gear_after_reset", {24'h0, gon}, 32'h0);
    rchk("ratio_after_reset", 8'h00, 32'h0);
    // Encoder, commanded and vector masters all run off the same three samples.
    wr(8'h04, 32'h3a98);
    wr(8'h08, 32'h2710);
    wr(8'h48, 32'h8);
    wr(8'h0c, 32'h4e20);
    wr(8'h4c, 32'h10);
    move[3] <= 32'h1;
    stepm(32'h3);
    stepm(32'h3);
    stepm(32'hfffffffd);
    rchk("slave_enc", 8'hc4, 32'h5);
    chk("slave_out", slave[1], 32'h5);
    rchk("slave_cmd", 8'hc8, 32'h15);
    rchk("slave_vec", 8'hcc, 32'h21);
    rchk("path_dist", 8'h88, 32'hf);
    chk("gear_on", {24'h0, gon}, 32'he);
    $display("gearing sources done");
    // Axis 2 is gantry, so stop and limit leave it geared while axis 1 drops out.
    wr(8'h20, 32'h4);
    @(posedge mclk); stop <= 8'h06;
    @(posedge mclk); stop <= 8'h00;
    repeat (2) @(posedge mclk);
    #1 chk("gear_stop", {24'h0, gon}, 32'hc);
    wr(8'h04, 32'h3a98);
    @(posedge mclk); limit <= 8'h06;
    repeat (5) @(posedge mclk);
    #1 chk("gear_limit", {24'h0, gon}, 32'hc);
    @(posedge mclk); limit <= 8'h00;
    wr(8'h08, 32'h0);
    #1 chk("gear_zero_gantry", {24'h0, gon}, 32'h8);
    $display("stop and gantry done");
    pulse_seq(3, 1'b1, 1'b0, 1'b0);
    pulse_seq(1, 1'b0, 1'b1, 1'b0);
    rchk("free_after", 8'h80, 32'h1fe);
    rchk("seg_after", 8'h84, 32'h1);
    rchk("total_len", 8'h8c, 32'h12c);
    rchk("bound_0", 8'ha0, 32'h15);
    rchk("bound_1", 8'ha4, 32'h0);
    pulse_seq(600, 1'b1, 1'b0, 1'b0);
    rchk("free_full", 8'h80, 32'h0);
    pulse_seq(1, 1'b0, 1'b0, 1'b1);
    rchk("free_clear", 8'h80, 32'h200);
    rchk("seg_clear", 8'h84, 32'h0);
    $display("sequence done");
    // A low enable must swallow both a servo sample and a register write.
    @(posedge mclk);
    ce <= 1'b0;
    stepm(32'h3);
    wr(8'h04, 32'h2710);
    @(posedge mclk);
    ce <= 1'b1;
    rchk("slave_frozen", 8'hc4, 32'h5);
    rchk("ratio_frozen", 8'h04, 32'h3a98);
    $display("enable hold done");
    wrap_up;
  end

  // The whole run needs under 10 us; this limit leaves a wide margin.
  initial begin
    #100000;
    fail_count++;
    wrap_up;
  end
endmodule // test_electronic_gearing_unit
`default_nettype wire
